// ===== rtl/serial_ctrl_defines.vh
`ifndef SERIAL_CTRL_DEFINES_VH
`define SERIAL_CTRL_DEFINES_VH

// ----------------------------------------
// operation control bit positions
// ----------------------------------------
`define OPC_TX_ENABLE 3'd0
`define OPC_PARITY_PLACE 3'd1
`define OPC_RX_ENABLE 3'd2
`define OPC_RX_FLAG_INHIBIT 3'd3
`define OPC_LOOPBACK 3'd4
`define OPC_PARITY_ENABLE 3'd5
`define OPC_INTERNAL_RESET 3'd6
`define OPC_EVEN_PARITY 3'd7

// ----------------------------------------
// frame format field positions
// ----------------------------------------
`define FMT_CPW_HI 3'd6
`define FMT_CPW_LO 3'd4
`define FMT_CLEN_HI 3'd3
`define FMT_CLEN_LO 3'd2
`define FMT_USED_MASK 8'h7c

// ----------------------------------------
// reset presets (word protocol: 8 bits x 4 chars, odd parity after data)
// ----------------------------------------
`define OPC_RESET 8'h25
`define FMT_RESET 8'h3c

// ----------------------------------------
// sequence states
// ----------------------------------------
`define SEQ_EXPECT_FORMAT 1'b0
`define SEQ_EXPECT_CONTROL 1'b1

`endif

// ===== rtl/pin_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// three-stage synchroniser, second and third must agree
// ----------------------------------------
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] s1;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;
	integer i;

	always @(posedge clk) begin
		if (rst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			dout <= INIT;
		end else if (ce) begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			// filter: only bits where stages agree move
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (s2[i] == s3[i]) begin
					dout[i] <= s3[i];
				end
			end
		end
	end
endmodule

// ===== rtl/frame_decode.v
`timescale 1ns/1ps
`include "serial_ctrl_defines.vh"
// ----------------------------------------
// frame format decode
// ----------------------------------------
module frame_decode (
	input wire [7:0] fmt,
	output wire [3:0] char_bits,
	output wire [3:0] chars_per_word
);
	function [3:0] plus_base;
		input [2:0] field;
		input [3:0] base;
		begin
			plus_base = {1'b0, field} + base;
		end
	endfunction

	// five plus the select value
	assign char_bits = plus_base({1'b0, fmt[`FMT_CLEN_HI:`FMT_CLEN_LO]}, 4'h5); // (R9)
	// field value plus one
	assign chars_per_word = plus_base(fmt[`FMT_CPW_HI:`FMT_CPW_LO], 4'h1); // (R10)
endmodule

// ===== rtl/serial_ctrl_host_registers.v
`timescale 1ns/1ps
`include "serial_ctrl_defines.vh"
// Overview of operation
// (R1) control bits: tx, place, rx, inhibit, loop, parity...
// (R2) enable bits switch each direction
// (R3) placement: parity inside word or after
// (R4) inhibit bit masks receiver-ready flag
// (R5) loopback bit selects local loop test
// (R6) parity enable and even/odd select
// (R7) internal reset re-expects mode write
// (R8) format: chars-per-word 6:4, length 3:2
// (R9) length select gives five to eight
// (R10) chars-per-word is field plus one
// (R11) cs,cd low, read low: receive data out
// (R12) cs,cd low, write low: transmit load
// (R13) cs low, cd high, read: status out
// (R14) cs low, cd high, write: control write
// (R15) chip select high: bus released
// (R16) inhibit clears at sequence end; not when a control write starts in the same cycle
// (R17) master reset presets both registers
// (R18) later control writes reach operation control
// (R19) first control write after reset is format
module serial_ctrl_host_registers (
	// clock, reset, enable
	input wire REF_CLK,
	input wire SYS_RST,
	input wire CLK_EN,
	// microprocessor bus pins
	input wire CS_N,
	input wire CD_SEL,
	input wire RD_N,
	input wire WR_N,
	input wire [7:0] DATA_IN,
	output reg [7:0] DATA_OUT,
	output wire DATA_OE,
	// receive side from serial engine
	input wire [7:0] RX_HOLDING,
	input wire RX_HOLDING_LOAD,
	input wire RX_SEQUENCE_DONE,
	input wire [7:0] STATUS_IN,
	output reg RX_HOLDING_READ,
	output wire RX_HOLDING_FULL_FLAG,
	// transmit side to serial engine
	output reg [7:0] TX_HOLDING,
	output reg TX_HOLDING_WRITE,
	// decoded configuration
	output wire TRANSMITTER_ENABLE,
	output wire RECEIVER_ENABLE,
	output wire PARITY_INSIDE,
	output wire LOOPBACK_TEST,
	output wire PARITY_ENABLE,
	output wire EVEN_PARITY,
	output wire [3:0] CHAR_BITS,
	output wire [3:0] CHARS_PER_WORD,
	output wire ENGINE_RESET,
	output wire SEQ_EXPECT_FORMAT
);
	// ----------------------------------------
	// synchronised strobes
	// ----------------------------------------
	wire [3:0] pins_sync;
	wire cs_n_s;
	wire cd_s;
	wire rd_n_s;
	wire wr_n_s;

	pin_sync #(
		.WIDTH(4),
		.INIT(4'hf)
	) u_sync (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.din({CS_N, CD_SEL, RD_N, WR_N}),
		.dout(pins_sync)
	);

	assign cs_n_s = pins_sync[3];
	assign cd_s = pins_sync[2];
	assign rd_n_s = pins_sync[1];
	assign wr_n_s = pins_sync[0];

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	wire sel = ~cs_n_s;
	wire rd_rx = sel & ~cd_s & ~rd_n_s & wr_n_s; // (R11)
	wire wr_tx = sel & ~cd_s & rd_n_s & ~wr_n_s; // (R12)
	wire rd_st = sel & cd_s & ~rd_n_s & wr_n_s; // (R13)
	wire wr_ctl = sel & cd_s & rd_n_s & ~wr_n_s; // (R14)

	// write data captured after a settled strobe; act once per strobe
	reg wr_prev;
	reg rd_prev;
	wire wr_any = wr_tx | wr_ctl;
	wire rd_any = rd_rx | rd_st;
	wire wr_start = wr_any & ~wr_prev;
	wire rd_start = rd_rx & ~rd_prev;

	// data bus sampled every cycle through two registers; the host holds it valid
	reg [7:0] bus_q1;
	reg [7:0] bus_q2;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	reg [7:0] operation_control;
	reg [7:0] frame_format;
	reg seq_state;
	reg rx_flag_raw;

	wire ir_write = wr_start & wr_ctl & (seq_state == `SEQ_EXPECT_CONTROL)
		& bus_q2[`OPC_INTERNAL_RESET];

	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			bus_q1 <= 8'h00;
			bus_q2 <= 8'h00;
		end else if (CLK_EN) begin
			bus_q1 <= DATA_IN;
			bus_q2 <= bus_q1;
		end
	end

	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			operation_control <= `OPC_RESET; // (R17)
			frame_format <= `FMT_RESET; // (R17)
			seq_state <= `SEQ_EXPECT_FORMAT; // (R19)
			wr_prev <= 1'b0;
			rd_prev <= 1'b0;
			TX_HOLDING <= 8'h00;
			TX_HOLDING_WRITE <= 1'b0;
			RX_HOLDING_READ <= 1'b0;
			rx_flag_raw <= 1'b0;
		end else if (CLK_EN) begin
			wr_prev <= wr_any;
			rd_prev <= rd_rx;
			TX_HOLDING_WRITE <= 1'b0;
			RX_HOLDING_READ <= 1'b0;
			if (wr_start & wr_tx) begin
				TX_HOLDING <= bus_q2; // (R12)
				TX_HOLDING_WRITE <= 1'b1;
			end
			if (rd_start) begin
				RX_HOLDING_READ <= 1'b1;
			end
			// a new character wins over a read in the same cycle
			if (RX_HOLDING_LOAD) begin
				rx_flag_raw <= 1'b1;
			end else if (rd_start) begin
				rx_flag_raw <= 1'b0;
			end
			if (ir_write) begin
				// internal reset: other bits taken from the written byte, reset bit itself cleared
				operation_control <= bus_q2 & ~(8'h01 << `OPC_INTERNAL_RESET);
				seq_state <= `SEQ_EXPECT_FORMAT; // (R7)
			end else if (wr_start & wr_ctl) begin
				case (seq_state)
					`SEQ_EXPECT_FORMAT: begin
						frame_format <= bus_q2 & `FMT_USED_MASK; // (R8)
						seq_state <= `SEQ_EXPECT_CONTROL; // (R19)
					end
					`SEQ_EXPECT_CONTROL: begin
						operation_control <= bus_q2; // (R18)
					end
					default: begin
						seq_state <= `SEQ_EXPECT_FORMAT;
					end
				endcase
			end else if (RX_SEQUENCE_DONE) begin
				operation_control[`OPC_RX_FLAG_INHIBIT] <= 1'b0; // (R16)
			end
		end
	end

	// ----------------------------------------
	// read data path
	// ----------------------------------------
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			DATA_OUT <= 8'h00;
		end else if (CLK_EN) begin
			if (rd_rx) begin
				DATA_OUT <= RX_HOLDING; // (R11)
			end else if (rd_st) begin
				DATA_OUT <= STATUS_IN; // (R13)
			end
		end
	end

	// released whenever chip select is high
	assign DATA_OE = rd_any & ~CS_N; // (R15)

	// ----------------------------------------
	// configuration outputs
	// ----------------------------------------
	assign TRANSMITTER_ENABLE = operation_control[`OPC_TX_ENABLE]; // (R1) (R2)
	assign RECEIVER_ENABLE = operation_control[`OPC_RX_ENABLE]; // (R2)
	assign PARITY_INSIDE = operation_control[`OPC_PARITY_PLACE]; // (R3)
	assign LOOPBACK_TEST = operation_control[`OPC_LOOPBACK]; // (R5)
	assign PARITY_ENABLE = operation_control[`OPC_PARITY_ENABLE]; // (R6)
	assign EVEN_PARITY = operation_control[`OPC_EVEN_PARITY]; // (R6)
	assign RX_HOLDING_FULL_FLAG = rx_flag_raw & RECEIVER_ENABLE
		& ~operation_control[`OPC_RX_FLAG_INHIBIT]; // (R4)
	// gated so a frozen clock does not stretch the pulse
	assign ENGINE_RESET = SYS_RST | (ir_write & CLK_EN); // (R7)
	assign SEQ_EXPECT_FORMAT = (seq_state == `SEQ_EXPECT_FORMAT);

	frame_decode u_fmt (
		.fmt(frame_format),
		.char_bits(CHAR_BITS),
		.chars_per_word(CHARS_PER_WORD)
	);
endmodule

// ===== testbench/serial_ctrl_host_registers_properties.sv
`timescale 1ns/1ps
// ----------------
// bus decode and register checks
// ----------------
module serial_ctrl_checks (
	input wire REF_CLK, SYS_RST, CS_N, CD_SEL, RD_N, WR_N, DATA_OE,
	input wire RX_HOLDING_READ, RX_HOLDING_FULL_FLAG, TX_HOLDING_WRITE, ENGINE_RESET,
	input wire TRANSMITTER_ENABLE, RECEIVER_ENABLE, PARITY_INSIDE, LOOPBACK_TEST,
	input wire PARITY_ENABLE, EVEN_PARITY, SEQ_EXPECT_FORMAT,
	input wire [7:0] DATA_IN, DATA_OUT, RX_HOLDING, STATUS_IN, TX_HOLDING,
	input wire [3:0] CHAR_BITS, CHARS_PER_WORD
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	wire [5:0] opc = {EVEN_PARITY, PARITY_ENABLE, LOOPBACK_TEST, RECEIVER_ENABLE,
		PARITY_INSIDE, TRANSMITTER_ENABLE};
	a_bus_released: assert property (CS_N |-> !DATA_OE)
		else $error("bus driven while deselected");
	a_tx_load: assert property (TX_HOLDING_WRITE |-> !CS_N && !CD_SEL && !WR_N
		&& TX_HOLDING == DATA_IN) else $error("bad transmit load");
	a_rx_read: assert property (RX_HOLDING_READ |-> !CS_N && !CD_SEL && !RD_N
		##[0:1] DATA_OUT == RX_HOLDING) else $error("bad receive read");
	a_status_out: assert property ($rose(DATA_OE) && CD_SEL |->
		##[1:2] DATA_OUT == STATUS_IN) else $error("bad status read");
	a_flag_enable: assert property (RX_HOLDING_FULL_FLAG |-> RECEIVER_ENABLE)
		else $error("flag with receiver off");
	a_reset_preset: assert property ($fell(SYS_RST) |-> opc == 6'h15
		&& CHAR_BITS == 4'h8 && CHARS_PER_WORD == 4'h4 && SEQ_EXPECT_FORMAT)
		else $error("bad reset preset");
	a_format_write: assert property ($fell(SEQ_EXPECT_FORMAT) |-> !CS_N && CD_SEL
		&& !WR_N && CHAR_BITS == 4'h5 + DATA_IN[3:2]
		&& CHARS_PER_WORD == 4'h1 + DATA_IN[6:4]) else $error("bad format write");
	a_ctl_write: assert property ($changed(opc) |-> !CS_N && CD_SEL && !WR_N
		&& opc == {DATA_IN[7], DATA_IN[5:4], DATA_IN[2:0]}) else $error("bad control write");
	a_internal_reset: assert property (ENGINE_RESET |-> ##[0:1] SEQ_EXPECT_FORMAT)
		else $error("internal reset kept control phase");
	c_format: cover property ($fell(SEQ_EXPECT_FORMAT));
	c_inhibit: cover property ($fell(RX_HOLDING_FULL_FLAG) && RECEIVER_ENABLE);
	c_status: cover property ($rose(DATA_OE) && CD_SEL);
endmodule
bind serial_ctrl_host_registers serial_ctrl_checks u_serial_ctrl_checks (.*);

// ===== testbench/host_bus_model.sv
`timescale 1ns/1ps
// ----------------
// microprocessor side
// ----------------
module host_bus_model (
	input wire REF_CLK,
	input wire [7:0] DATA_OUT,
	input wire DATA_OE,
	output logic CS_N = 1'b1, CD_SEL = 1'b0, RD_N = 1'b1, WR_N = 1'b1,
	output logic [7:0] DATA_IN = 8'h00
);
	// fixed long hold: the pins pass a slow synchroniser
	task automatic xfer(input logic cs, cd, w, input logic [7:0] d, output logic [7:0] q);
		@(posedge REF_CLK) #1;
		CS_N = cs;
		CD_SEL = cd;
		RD_N = w;
		WR_N = !w;
		DATA_IN = w ? d : ~d;
		repeat (8) @(posedge REF_CLK);
		q = DATA_OE ? DATA_OUT : 8'hzz;
		#1 {CS_N, RD_N, WR_N} = 3'h7;
		DATA_IN = ~DATA_IN; // released bus shows no stale value
		repeat (6) @(posedge REF_CLK);
	endtask
endmodule

// ===== testbench/serial_ctrl_host_registers_test.sv
`timescale 1ns/1ps
module serial_ctrl_host_registers_test;
	logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, ld = 1'b0, done = 1'b0;
	logic [7:0] rxh = 8'h3c, sts = 8'hc3, q;
	wire cs_n, cd, rd_n, wr_n, oe, rrd, full, txw, txe, rxe, pins, loopback_test_bit, parity_enable_bit, even_parity_select, erst, seqf;
	wire [7:0] din, dout, txh;
	wire [3:0] cbits, cpw;
	int error_cnt = 0, checks = 0, wcnt = 0, rcnt = 0;
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		wcnt += (txw === 1'b1);
		rcnt += (rrd === 1'b1);
	end
	serial_ctrl_host_registers u_serial_ctrl_host_registers (.REF_CLK(ref_clk),
		.SYS_RST(sys_rst), .CLK_EN(clk_en), .CS_N(cs_n), .CD_SEL(cd), .RD_N(rd_n),
		.WR_N(wr_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .RX_HOLDING(rxh),
		.RX_HOLDING_LOAD(ld), .RX_SEQUENCE_DONE(done), .STATUS_IN(sts),
		.RX_HOLDING_READ(rrd), .RX_HOLDING_FULL_FLAG(full), .TX_HOLDING(txh),
		.TX_HOLDING_WRITE(txw), .TRANSMITTER_ENABLE(txe), .RECEIVER_ENABLE(rxe),
		.PARITY_INSIDE(pins), .LOOPBACK_TEST(loopback_test_bit), .PARITY_ENABLE(parity_enable_bit), .EVEN_PARITY(even_parity_select),
		.CHAR_BITS(cbits), .CHARS_PER_WORD(cpw), .ENGINE_RESET(erst), .SEQ_EXPECT_FORMAT(seqf));
	host_bus_model u_host_bus_model (.REF_CLK(ref_clk), .DATA_OUT(dout), .DATA_OE(oe),
		.CS_N(cs_n), .CD_SEL(cd), .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(din));
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic cs, c, w, input logic [7:0] d);
		u_host_bus_model.xfer(cs, c, w, d, q);
	endtask
	task automatic pulse(input logic l);
		@(posedge ref_clk) #1;
		if (l) ld = 1'b1;
		else done = 1'b1;
		@(posedge ref_clk) #1;
		{ld, done} = 2'b00;
		@(posedge ref_clk) #1;
	endtask
	function automatic logic [7:0] opb();
		return {even_parity_select, 1'b0, parity_enable_bit, loopback_test_bit, 1'b0, rxe, pins, txe};
	endfunction
	task automatic t_reset();
		chk(opb(), 8'h25);
		chk({cbits, cpw}, 8'h84);
	endtask
	task automatic t_bus();
		bus(1'b0, 1'b0, 1'b1, 8'ha5);
		bus(1'b0, 1'b0, 1'b1, 8'h5a);
		chk(txh, 8'h5a);
		bus(1'b0, 1'b0, 1'b0, 8'h00);
		chk(q, 8'h3c);
		bus(1'b0, 1'b1, 1'b0, 8'h00);
		chk(q, 8'hc3);
		bus(1'b1, 1'b0, 1'b0, 8'h00);
		chk(q, 8'hzz);
		bus(1'b1, 1'b0, 1'b1, 8'hff);
		chk(txh, 8'h5a);
		chk(8'(wcnt * 16 + rcnt), 8'h21);
		chk(seqf, 1'b1);
	endtask
	task automatic t_cfg();
		logic [7:0] fmt [4] = '{8'h80, 8'h17, 8'h68, 8'hfc};
		logic [7:0] op [4] = '{8'h95, 8'h2a, 8'hb5, 8'h00};
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 1'b1, 1'b1, fmt[i]);
			chk({cbits, cpw}, {4'h5 + fmt[i][3:2], 4'h1 + fmt[i][6:4]});
			bus(1'b0, 1'b1, 1'b1, op[i]);
			chk(opb(), op[i] & 8'hb7);
			bus(1'b0, 1'b1, 1'b1, 8'h40);
			chk(opb(), 8'h00);
			chk(seqf, 1'b1);
		end
	endtask
	task automatic t_flag();
		bus(1'b0, 1'b1, 1'b1, 8'h3c);
		bus(1'b0, 1'b1, 1'b1, 8'h04);
		pulse(1'b1);
		chk(full, 1'b1);
		bus(1'b0, 1'b1, 1'b1, 8'h0c);
		chk(full, 1'b0);
		pulse(1'b0);
		chk(full, 1'b1);
		bus(1'b0, 1'b1, 1'b1, 8'h00);
		chk(full, 1'b0);
		bus(1'b0, 1'b1, 1'b1, 8'h04);
		bus(1'b0, 1'b0, 1'b0, 8'h00);
		chk(full, 1'b0);
	endtask
	task automatic conclude();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		t_reset();
		t_bus();
		t_cfg();
		t_flag();
		conclude();
	end
	// whole run is near one and a half microseconds
	initial begin
		#20000;
		error_cnt++;
		conclude();
	end
endmodule
